// ---- common/trxcf_map.svh ----
// Offsets, field positions, reset values and counts of the transceiver register bank.
// Assumes it is included by bare name from the package only; the design module uses the macros that this include defines.
// Functional notes
// - Sixteen-byte data buffer and six 8-bit control registers, all read and writable except reserved bit 3 of register one.
// - One 8-bit status register outside the RAM, read only for the host.
// - Contents kept while powered; turn-on reset loads every control register default.
// - RX interrupt at 4, 8 or 12 buffered bytes or error; code 11 error only.
// - TX interrupt at 4, 8 or 12 bytes left or empty; code 11 empty only.
// - Mode field bits 2:1 of register one: idle, transmit, polling, receive.
// - Transparent bit bypasses buffer; TX data from input pin, RX data to output.
// - Tuning word is thirteen bits from register two and register three fields.
// - Register two bit 0: RX bit-check interrupt mask, TX Manchester or NRZ.
// - Register three bits 1 and 0 enable supply output and clock output.
// - Bit check success in receive or polling mode, key event or power-on flag force both enables on.
// - Register four bit 7 selects FSK when clear, ASK when set.
// - Sleep time is field times 1024 data clocks, times eight when stretched.
// - Register four bit 0 doubles the bit timing clock and edge limits.
// - Bit check length is 0, 3, 6 or 9 bits from register five.
// - Minimum edge time is field times bit timing period; below 10 invalid.
// - TX bit period is field plus one, times bit timing period, times two.
// - Rate range sets bit timing period to 8, 4, 2 or 1 data clocks.
// - Maximum edge time is field minus one times bit timing period; below 12 invalid.
// - Power-on flag, auxiliary flag or key event raise the interrupt request.
// - Status read clears power-on, low battery, auxiliary flags and the interrupt.
// - Every serial byte travels most significant bit first in both directions.
`ifndef TRXCF_MAP_SVH
`define TRXCF_MAP_SVH

`define TRXCF_ADDR_IRQ_MODE 4'h0
`define TRXCF_ADDR_TUNE_LOW 4'h1
`define TRXCF_ADDR_TUNE_HIGH 4'h2
`define TRXCF_ADDR_MOD_SLEEP 4'h3
`define TRXCF_ADDR_BITCHK_MIN 4'h4
`define TRXCF_ADDR_RATE_MAX 4'h5
`define TRXCF_ADDR_STATUS 4'h8
`define TRXCF_NUM_CTL 6

`define TRXCF_RST_IRQ_MODE 8'h80
`define TRXCF_RST_TUNE_LOW 8'hb0
`define TRXCF_RST_TUNE_HIGH 8'h7b
`define TRXCF_RST_MOD_SLEEP 8'h28
`define TRXCF_RST_BITCHK_MIN 8'h50
`define TRXCF_RST_RATE_MAX 8'h9c
`define TRXCF_CTL1_WMASK 8'hf7

`define TRXCF_BUF_DEPTH 16
`define TRXCF_LVL_A 5'h04
`define TRXCF_LVL_B 5'h08
`define TRXCF_LVL_C 5'h0c
`define TRXCF_SLEEP_UNIT 18'h00400
`define TRXCF_SLEEP_STRETCH 18'h00008
`define TRXCF_BTP_MAX 5'h08
`define TRXCF_BITCHK_STEP 4'h3
`define TRXCF_MIN_VALID 6'h0a
`define TRXCF_MAX_VALID 6'h0c

`endif

// ---- common/trxcf_pkg.sv ----
// Types shared by the transceiver register bank.
// Assumes the map header sits beside it on the include path.
package trxcf_pkg;
    `include "trxcf_map.svh"

    typedef enum logic [1:0] {
        TRXCF_IDLE,
        TRXCF_TX,
        TRXCF_RX_POLL,
        TRXCF_RX
    } trxcf_opmode_e;

    typedef struct packed {
        logic [`TRXCF_NUM_CTL-1:0][7:0] ctl;
        logic [`TRXCF_BUF_DEPTH-1:0][7:0] mem;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [4:0] count;
        logic [4:0] key_status;
        logic pwr_flag;
        logic batt_flag;
        logic aux_flag;
        logic irq;
        logic [7:0] rdata;
    } trxcf_state_s;
endpackage : trxcf_pkg

// ---- verilog/trxcf_regs.sv ----
// Control and status register bank with the shared TX/RX byte buffer.
// Assumes a serial engine turns the four-wire port into register and buffer strobes,
// shifting each byte most significant bit first, and that arst_n is the turn-on reset.
`timescale 1ns/100ps
module trxcf_regs
    import trxcf_pkg::*;
#(
    parameter int BUF_DEPTH = `TRXCF_BUF_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Register port from the serial engine
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Buffer port from the serial engine
    input wire logic host_buf_wr,
    input wire logic [7:0] host_buf_wdata,
    input wire logic host_buf_rd,
    output logic [7:0] buf_head,
    output logic [4:0] buf_count,
    // Radio datapath
    input wire logic rx_push,
    input wire logic [7:0] rx_byte,
    input wire logic tx_pop,
    input wire logic rx_error,
    input wire logic bitcheck_ok,
    // Wake and supply events
    input wire logic key_event,
    input wire logic [4:0] key_pressed,
    input wire logic key_debounce_active,
    input wire logic pwr_on_event,
    input wire logic aux_event,
    input wire logic low_batt_level,
    // Transparent path
    input wire logic serial_in_pin,
    input wire logic spi_sdo,
    input wire logic rx_demod,
    output logic serial_out_pin,
    output logic tx_mod_data,
    output logic transparent_mode,
    // Configuration towards the radio
    output trxcf_opmode_e op_mode,
    output logic analog_supply_enable,
    output logic band_select,
    output logic [12:0] tuning_word,
    output logic manchester_en,
    output logic bitcheck_irq_en,
    output logic modulation_select,
    output logic [17:0] sleep_cycles,
    output logic [4:0] bit_timing_cycles,
    output logic [9:0] min_edge_cycles,
    output logic [9:0] max_edge_cycles,
    output logic [11:0] tx_bit_cycles,
    output logic [3:0] bitcheck_bits,
    output logic min_limit_invalid,
    output logic max_limit_invalid,
    output logic ext_supply_out_enable,
    output logic clk_out_enable,
    output logic irq
);

    if (BUF_DEPTH != `TRXCF_BUF_DEPTH) begin : g_depth_check
        $error("trxcf_regs: the buffer pointers serve a depth of sixteen only");
    end

    trxcf_state_s s;
    trxcf_state_s next_s;
    logic tmode;
    logic rx_any;
    logic tx_mode;
    logic wr_en;
    logic rd_en;
    logic [4:0] lvl;
    logic lvl_on;
    logic [4:0] next_count;
    logic stat_rd;
    logic force_on;
    logic [7:0] status_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded controls.

    assign tmode = s.ctl[0][0];
    assign op_mode = trxcf_opmode_e'(s.ctl[0][2:1]);
    assign rx_any = (op_mode == TRXCF_RX) || (op_mode == TRXCF_RX_POLL);
    assign tx_mode = (op_mode == TRXCF_TX);
    assign stat_rd = reg_rd && (reg_addr == `TRXCF_ADDR_STATUS);
    // A power-on event forces the enables in the cycle that sets the flag.
    // Waiting for the flag would leave the supply off for one cycle.
    assign force_on = (bitcheck_ok && rx_any) || key_event || key_debounce_active
        || pwr_on_event || s.pwr_flag;
    assign status_byte = {s.key_status, s.pwr_flag, s.batt_flag, s.aux_flag};

    // The buffer is frozen in transparent mode so stale bytes cannot leak out later.
    assign wr_en = !tmode && (s.count != 5'(BUF_DEPTH))
        && (host_buf_wr || (rx_push && rx_any));
    assign rd_en = !tmode && (s.count != 5'h00)
        && (host_buf_rd || (tx_pop && tx_mode));
    assign next_count = s.count + {4'h0, wr_en} - {4'h0, rd_en};

    always_comb begin
        lvl = `TRXCF_LVL_C;
        lvl_on = 1'b1;
        unique case (s.ctl[0][7:6])
            2'b00: lvl = `TRXCF_LVL_A;
            2'b01: lvl = `TRXCF_LVL_B;
            2'b10: lvl = `TRXCF_LVL_C;
            2'b11: lvl_on = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_s = s;
        // Register writes; the status address takes no writes.
        if (reg_wr && (reg_addr < 4'(`TRXCF_NUM_CTL))) begin
            next_s.ctl[reg_addr[2:0]] = reg_wdata;
        end
        next_s.ctl[0] = next_s.ctl[0] & `TRXCF_CTL1_WMASK;
        // Forcing wins over a host write to the enables in the same cycle.
        if (force_on) begin
            next_s.ctl[2][1:0] = 2'b11;
        end
        // Register read data, with unmapped addresses reading zero.
        if (reg_rd) begin
            if (reg_addr < 4'(`TRXCF_NUM_CTL)) begin
                next_s.rdata = s.ctl[reg_addr[2:0]];
            end else if (reg_addr == `TRXCF_ADDR_STATUS) begin
                next_s.rdata = status_byte;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
        // Buffer.
        if (wr_en) begin
            next_s.mem[s.wptr] = host_buf_wr ? host_buf_wdata : rx_byte;
            next_s.wptr = s.wptr + 4'h1;
        end
        if (rd_en) begin
            next_s.rptr = s.rptr + 4'h1;
        end
        next_s.count = next_count;
        // Status flags: the read clears first so that a same-cycle event survives.
        if (stat_rd) begin
            next_s.pwr_flag = 1'b0;
            next_s.aux_flag = 1'b0;
            next_s.batt_flag = 1'b0;
            next_s.irq = 1'b0;
        end
        if (low_batt_level) begin
            next_s.batt_flag = 1'b1;
        end
        if (key_event) begin
            next_s.key_status = key_pressed;
            next_s.irq = 1'b1;
        end
        if (pwr_on_event) begin
            next_s.pwr_flag = 1'b1;
            if (!s.pwr_flag) begin
                next_s.irq = 1'b1;
            end
        end
        if (aux_event) begin
            next_s.aux_flag = 1'b1;
            if (!s.aux_flag) begin
                next_s.irq = 1'b1;
            end
        end
        // Buffer level and radio events.
        if (rx_any && !tmode) begin
            if (rx_error || (lvl_on && wr_en && !rd_en && (next_count == lvl))) begin
                next_s.irq = 1'b1;
            end
        end
        if (rx_any && bitcheck_ok && !s.ctl[1][0]) begin
            next_s.irq = 1'b1;
        end
        if (tx_mode && !tmode && rd_en && !wr_en) begin
            if ((next_count == 5'h00) || (lvl_on && (next_count == lvl))) begin
                next_s.irq = 1'b1;
            end
        end
    end

    // Turn-on reset: defaults in every control register, buffer and flags empty.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ctl[0] <= `TRXCF_RST_IRQ_MODE;
            s.ctl[1] <= `TRXCF_RST_TUNE_LOW;
            s.ctl[2] <= `TRXCF_RST_TUNE_HIGH;
            s.ctl[3] <= `TRXCF_RST_MOD_SLEEP;
            s.ctl[4] <= `TRXCF_RST_BITCHK_MIN;
            s.ctl[5] <= `TRXCF_RST_RATE_MAX;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // The serial engine shifts every byte out from bit 7 down.
    assign reg_rdata = s.rdata;
    assign buf_head = s.mem[s.rptr];
    assign buf_count = s.count;
    assign irq = s.irq;
    assign transparent_mode = tmode;
    assign serial_out_pin = tmode ? rx_demod : spi_sdo;
    assign tx_mod_data = tmode ? serial_in_pin : 1'b0;
    assign analog_supply_enable = s.ctl[0][5];
    assign band_select = s.ctl[0][4];
    assign tuning_word = {s.ctl[2][7:2], s.ctl[1][7:1]};
    assign manchester_en = !s.ctl[1][0];
    assign bitcheck_irq_en = !s.ctl[1][0];
    assign ext_supply_out_enable = s.ctl[2][1];
    assign clk_out_enable = s.ctl[2][0];
    assign modulation_select = s.ctl[3][7];
    // The products are sized for the largest fields; a maximum limit of zero wraps,
    // but such a value is flagged invalid anyway.
    assign sleep_cycles = 18'(s.ctl[3][6:2]) * `TRXCF_SLEEP_UNIT
        * (s.ctl[3][1] ? `TRXCF_SLEEP_STRETCH : 18'h00001);
    assign bit_timing_cycles = (`TRXCF_BTP_MAX >> s.ctl[5][7:6])
        << s.ctl[3][0];
    assign bitcheck_bits = {2'b00, s.ctl[4][7:6]} * `TRXCF_BITCHK_STEP;
    assign min_edge_cycles = 10'(s.ctl[4][5:0]) * 10'(bit_timing_cycles);
    assign max_edge_cycles = (10'(s.ctl[5][5:0]) - 10'h001)
        * 10'(bit_timing_cycles);
    assign tx_bit_cycles = (12'(s.ctl[4][5:0]) + 12'h001) * 12'(bit_timing_cycles)
        * 12'h002;
    assign min_limit_invalid = s.ctl[4][5:0] < `TRXCF_MIN_VALID;
    assign max_limit_invalid = s.ctl[5][5:0] < `TRXCF_MAX_VALID;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Register port: writes land and reads answer one cycle after the strobe.
    ctl_write_a: assert property (
        reg_wr && reg_addr == `TRXCF_ADDR_MOD_SLEEP |=> s.ctl[3] == $past(reg_wdata))
        else $error("register write lost");

    status_ro_a: assert property (
        reg_wr && reg_addr == `TRXCF_ADDR_STATUS && !force_on |=> $stable(s.ctl))
        else $error("status write touched control");

    reserved_bit_a: assert property (!s.ctl[0][3])
        else $error("reserved bit of register one is set");

    reserved_read_a: assert property (
        reg_rd && reg_addr == 4'h0 |=> !reg_rdata[3])
        else $error("reserved bit of register one read back as one");

    unmapped_read_a: assert property (
        reg_rd && reg_addr >= 4'(`TRXCF_NUM_CTL) && reg_addr != `TRXCF_ADDR_STATUS
        |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // Status flags and the interrupt line.
    status_clear_a: assert property (
        stat_rd && !pwr_on_event && !aux_event && !low_batt_level && !key_event
        |=> !s.pwr_flag && !s.aux_flag && !s.batt_flag)
        else $error("status read did not clear flags");

    irq_hold_a: assert property (irq && !stat_rd |=> irq)
        else $error("interrupt dropped without a status read");

    pwr_irq_a: assert property (
        pwr_on_event && !s.pwr_flag |=> irq && s.pwr_flag && ext_supply_out_enable)
        else $error("power-on event not flagged");

    aux_irq_a: assert property (
        aux_event && !s.aux_flag |=> irq && s.aux_flag)
        else $error("auxiliary supply event not flagged");

    key_irq_a: assert property (
        key_event |=> irq && s.key_status == $past(key_pressed))
        else $error("key event not recorded");

    set_wins_a: assert property (stat_rd && key_event |=> irq)
        else $error("status read hid a same-cycle key event");

    batt_set_a: assert property (low_batt_level |=> s.batt_flag)
        else $error("low battery flag not set");

    // Output enables.
    force_on_a: assert property (
        key_event |=> ext_supply_out_enable && clk_out_enable)
        else $error("key event did not force output enables");

    pwr_hold_a: assert property (
        s.pwr_flag |=> ext_supply_out_enable && clk_out_enable)
        else $error("power-on flag did not hold output enables");

    bitchk_force_a: assert property (
        bitcheck_ok && rx_any |=> ext_supply_out_enable && clk_out_enable)
        else $error("bit check did not force output enables");

    // Buffer levels and bounds.
    rx_level_irq_a: assert property (
        rx_any && !tmode && wr_en && !rd_en && lvl_on && next_count == lvl |=> irq)
        else $error("rx level interrupt missing");

    rx_error_irq_a: assert property (rx_error && rx_any && !tmode |=> irq)
        else $error("rx error interrupt missing");

    bitchk_irq_a: assert property (
        rx_any && bitcheck_ok && bitcheck_irq_en |=> irq)
        else $error("bit check interrupt missing");

    tx_empty_irq_a: assert property (
        tx_mode && !tmode && s.count == 5'h01 && rd_en && !wr_en |=> irq && buf_count == 5'h00)
        else $error("tx empty interrupt missing");

    count_bound_a: assert property (buf_count <= 5'(BUF_DEPTH))
        else $error("buffer count above depth");

    empty_pop_a: assert property (
        s.count == 5'h00 && !wr_en |=> buf_count == 5'h00)
        else $error("pop from empty buffer moved the count");

    full_push_a: assert property (
        s.count == 5'(BUF_DEPTH) && !rd_en |=> buf_count == 5'(BUF_DEPTH))
        else $error("push into full buffer moved the count");

    transp_freeze_a: assert property (tmode |=> buf_count == $past(buf_count))
        else $error("buffer moved in transparent mode");

    // Derived timing.
    sleep_calc_a: assert property (
        sleep_cycles == 18'(s.ctl[3][6:2]) * 18'd1024 * (s.ctl[3][1] ? 18'd8 : 18'd1))
        else $error("sleep time wrong");

    rate_calc_a: assert property (
        s.ctl[5][7:6] == 2'b10 && !s.ctl[3][0] |-> bit_timing_cycles == 5'd2)
        else $error("bit timing period wrong");

    bitchk_range_a: assert property (bitcheck_bits <= 4'd9)
        else $error("bit check length out of range");

    // Main scenarios.
    rx_fill_c: cover property (rx_any && wr_en ##1 irq);
    tx_drain_c: cover property (tx_mode && rd_en && s.count == 5'h01);
    status_read_c: cover property (s.pwr_flag && stat_rd ##1 !irq);
    transparent_c: cover property (tmode && serial_in_pin);
    key_event_c: cover property (key_event ##1 irq);

endmodule : trxcf_regs

// ---- dv/trxcf_host_model.sv ----
// Host side model: turns one bench request into a one-cycle register strobe.
// Assumes requests arrive at least three cycles apart, driven at the rising edge.
`timescale 1ns/100ps
module trxcf_host_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Request from the bench
    input wire logic req,
    input wire logic req_wr,
    input wire logic aux_mode,
    input wire logic [3:0] req_addr,
    input wire logic [7:0] req_data,
    // Register port of the bank
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    // The host never switches the supply output off while running from the auxiliary input.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            reg_addr <= 4'h0;
            reg_wdata <= 8'h00;
        end else begin
            reg_wr <= req & req_wr;
            reg_rd <= req & ~req_wr;
            // Bytes arrive whole; the serial engine has shifted them bit 7 first.
            reg_addr <= req_addr;
            reg_wdata <= req_data | {6'h00, aux_mode && req_addr == 4'h2, 1'b0};
        end
    end
endmodule : trxcf_host_model

// ---- dv/trxcf_regs_tb_top.sv ----
// Self-checking bench for the transceiver register bank.
// Assumes the host model drives the register port and the bench drives all else.
`timescale 1ns/100ps
module trxcf_regs_tb_top;
    import trxcf_pkg::*;
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } trxcf_row_s;
    logic core_clk, arst_n, req, req_wr, aux_mode, host_buf_rd, key_debounce_active;
    logic low_batt_level, serial_in_pin, spi_sdo, rx_demod, reg_wr, reg_rd, irq;
    logic serial_out_pin, tx_mod_data, modulation_select, min_limit_invalid;
    logic transparent_mode, analog_supply_enable, band_select, manchester_en, bitcheck_irq_en;
    logic max_limit_invalid, ext_supply_out_enable, clk_out_enable;
    wire logic rx_push, tx_pop, host_buf_wr, rx_error, bitcheck_ok, key_event;
    wire logic pwr_on_event, aux_event;
    logic [7:0] ev, req_data, reg_wdata, reg_rdata, host_buf_wdata, rx_byte, buf_head;
    logic [3:0] req_addr, reg_addr, bitcheck_bits;
    logic [4:0] key_pressed, buf_count, bit_timing_cycles;
    logic [9:0] min_edge_cycles, max_edge_cycles;
    logic [11:0] tx_bit_cycles;
    logic [12:0] tuning_word;
    logic [17:0] sleep_cycles;
    trxcf_opmode_e op_mode;
    int failures, check_count, cyc;
    trxcf_row_s rows [13] = '{'{0, 0, 0, 8'h80}, '{0, 1, 0, 8'hb0}, '{0, 2, 0, 8'h7b},
        '{0, 3, 0, 8'h28}, '{0, 4, 0, 8'h50}, '{0, 5, 0, 8'h9c}, '{0, 8, 0, 8'h00},
        '{1, 0, 8'hff, 8'hf7}, '{1, 6, 8'hff, 8'h00}, '{1, 4, 8'hca, 8'hca},
        '{1, 5, 8'hcc, 8'hcc}, '{1, 3, 8'h8b, 8'h8b}, '{1, 8, 8'hff, 8'h00}};
    assign {rx_push, tx_pop, host_buf_wr, rx_error, bitcheck_ok, key_event} = ev[7:2];
    assign {pwr_on_event, aux_event} = ev[1:0];

    trxcf_host_model trxcf_host_model_inst (.core_clk, .arst_n, .req, .req_wr, .aux_mode,
        .req_addr, .req_data, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    trxcf_regs trxcf_regs_inst (.core_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .host_buf_wr, .host_buf_wdata, .host_buf_rd, .buf_head, .buf_count,
        .rx_push, .rx_byte, .tx_pop, .rx_error, .bitcheck_ok, .key_event, .key_pressed,
        .key_debounce_active, .pwr_on_event, .aux_event, .low_batt_level, .serial_in_pin,
        .spi_sdo, .rx_demod, .serial_out_pin, .tx_mod_data, .transparent_mode, .op_mode,
        .analog_supply_enable, .band_select, .tuning_word, .manchester_en,
        .bitcheck_irq_en, .modulation_select, .sleep_cycles, .bit_timing_cycles,
        .min_edge_cycles, .max_edge_cycles, .tx_bit_cycles, .bitcheck_bits,
        .min_limit_invalid, .max_limit_invalid, .ext_supply_out_enable, .clk_out_enable,
        .irq);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Returns at the falling edge after the bank took the strobe, so results are settled.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= 1'b1;
        req_wr <= w;
        req_addr <= a;
        req_data <= d;
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : acc

    task automatic pulse(input logic [7:0] m, input int n);
        @(posedge core_clk);
        ev <= m;
        repeat (n) @(posedge core_clk);
        ev <= 8'h00;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask : pulse

    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        {arst_n, req, req_wr, aux_mode, host_buf_rd, key_debounce_active} = '0;
        {low_batt_level, serial_in_pin, spi_sdo, rx_demod, ev, req_addr, req_data} = '0;
        {key_pressed, failures, check_count, cyc} = '0;
        host_buf_wdata = 8'h3c;
        rx_byte = 8'ha5;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            if (i == 7) begin
                chk("tuning", 18'd3928, 18'(tuning_word));
                chk("tx_bit", 18'd68, 18'(tx_bit_cycles));
                chk("max_edge", 18'd54, 18'(max_edge_cycles));
                chk("enables", 18'h3, 18'({ext_supply_out_enable, clk_out_enable}));
            end
            if (rows[i].wr) acc(1'b1, rows[i].addr, rows[i].data);
            acc(1'b0, rows[i].addr, 8'h00);
            chk("rdata", 18'(rows[i].exp), 18'(reg_rdata));
        end
        chk("sleep", 18'd16384, sleep_cycles);
        chk("min_edge", 18'd20, 18'(min_edge_cycles));
        chk("max_edge", 18'd22, 18'(max_edge_cycles));
        chk("bitcheck", 18'd9, 18'(bitcheck_bits));
        chk("ctl0_bits", 18'h7, 18'({analog_supply_enable, band_select, transparent_mode}));
        chk("p_mode", 18'h3, 18'({manchester_en, bitcheck_irq_en}));
        chk("bit_timing", 18'd2, 18'(bit_timing_cycles));
        chk("modulation", 18'h1, 18'(modulation_select));
        acc(1'b1, 4'h4, 8'h09);
        chk("min_invalid", 18'h1, 18'(min_limit_invalid));
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, 4'h0, 8'(m * 2));
            chk("op_mode", 18'(m), 18'(op_mode));
        end
        pulse(8'h80, 3);
        chk("irq", 18'h0, 18'(irq));
        pulse(8'h80, 1);
        chk("irq", 18'h1, 18'(irq));
        acc(1'b0, 4'h8, 8'h00);
        chk("irq", 18'h0, 18'(irq));
        acc(1'b1, 4'h0, 8'hc6);
        pulse(8'h80, 4);
        chk("irq", 18'h0, 18'(irq));
        pulse(8'h08, 1);
        chk("irq", 18'h1, 18'(irq));
        acc(1'b0, 4'h8, 8'h00);
        pulse(8'h10, 1);
        chk("irq", 18'h1, 18'(irq));
        acc(1'b0, 4'h8, 8'h00);
        acc(1'b1, 4'h0, 8'h02);
        pulse(8'h20, 1);
        pulse(8'h40, 5);
        chk("irq", 18'h1, 18'(irq));
        acc(1'b0, 4'h8, 8'h00);
        pulse(8'h40, 3);
        chk("head", 18'h3c, 18'(buf_head));
        pulse(8'h40, 1);
        chk("count_irq", 18'h1, 18'({buf_count, irq}));
        acc(1'b1, 4'h0, 8'h01);
        @(posedge core_clk);
        serial_in_pin <= 1'b1;
        rx_demod <= 1'b1;
        @(negedge core_clk);
        chk("transparent", 18'h3, 18'({tx_mod_data, serial_out_pin}));
        pulse(8'h03, 1);
        chk("irq", 18'h1, 18'(irq));
        acc(1'b1, 4'h2, 8'h78);
        chk("enables", 18'h3, 18'({ext_supply_out_enable, clk_out_enable}));
        acc(1'b0, 4'h8, 8'h00);
        chk("status", 18'h05, 18'(reg_rdata));
        aux_mode <= 1'b1;
        acc(1'b1, 4'h2, 8'h78);
        chk("enables", 18'h2, 18'({ext_supply_out_enable, clk_out_enable}));
        aux_mode <= 1'b0;
        acc(1'b1, 4'h2, 8'h78);
        chk("enables", 18'h0, 18'({ext_supply_out_enable, clk_out_enable}));
        key_pressed <= 5'h01;
        pulse(8'h04, 1);
        acc(1'b0, 4'h8, 8'h00);
        chk("status", 18'h08, 18'(reg_rdata));
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(posedge core_clk);
        arst_n <= 1'b1;
        acc(1'b0, 4'h2, 8'h00);
        chk("rdata", 18'h7b, 18'(reg_rdata));
        report_and_stop();
    end
endmodule : trxcf_regs_tb_top
